// file: ccu_pkg.sv
// Constants, field layouts and decode helpers for the two-unit capture/compare block.
// Assumes an APB slave with 32-bit data; each 8-bit register sits in the low byte of a word.

package ccu_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_TBC  = 8'h00;  // timebase_b_control
  localparam logic [7:0] OFS_U1L  = 8'h04;  // unit1_value_low
  localparam logic [7:0] OFS_U1H  = 8'h08;  // unit1_value_high
  localparam logic [7:0] OFS_U1C  = 8'h0c;  // unit1_control
  localparam logic [7:0] OFS_U2L  = 8'h10;  // unit2_value_low
  localparam logic [7:0] OFS_U2H  = 8'h14;  // unit2_value_high
  localparam logic [7:0] OFS_U2C  = 8'h18;  // unit2_control
  localparam logic [7:0] OFS_FLAG = 8'h1c;  // match flags, write one to clear
  localparam logic [7:0] OFS_IEN  = 8'h20;  // match interrupt enables

  // ==========================================================================
  // Field positions and masks
  localparam int unsigned TBC_SEL_HI = 6;      // timebase_select_hi
  localparam int unsigned TBC_SEL_LO = 3;      // timebase_select_lo
  localparam int unsigned CTRL_DC_LSB = 4;     // duty_low_bit0 position
  localparam logic [7:0]  CTRL1_MASK = 8'hff;  // unit 1: output_mode bits present
  localparam logic [7:0]  CTRL2_MASK = 8'h3f;  // unit 2: bits 7:6 absent

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [7:0]  RST_TBC  = 8'h00;
  localparam logic [15:0] RST_VAL  = 16'h0000;
  localparam logic [1:0]  RST_IEN  = 2'h0;

  // ==========================================================================
  // Mode select field encodings
  localparam logic [3:0] MODE_OFF    = 4'h0;  // unit off
  localparam logic [3:0] MODE_TOGGLE = 4'h2;  // compare, toggle on match
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;  // capture every falling edge
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;  // capture every rising edge
  localparam logic [3:0] MODE_CAP_R4   = 4'h6;  // capture every 4th rising
  localparam logic [3:0] MODE_CAP_R16  = 4'h7;  // capture every 16th rising
  localparam logic [3:0] MODE_SET_HI = 4'h8;  // init low, drive high on match
  localparam logic [3:0] MODE_SET_LO = 4'h9;  // init high, drive low on match
  localparam logic [3:0] MODE_SWINT  = 4'ha;  // flag only
  localparam logic [3:0] MODE_SEV    = 4'hb;  // special event trigger

  // ==========================================================================
  // Decode helpers

  // Compare modes: toggle and the 10xx group
  function automatic logic is_compare(input logic [3:0] mode);
    is_compare = (mode[3:2] == 2'b10) || (mode == MODE_TOGGLE);
  endfunction : is_compare

  // Modes whose pin follows the compare latch rather than the port latch
  function automatic logic drives_pin(input logic [3:0] mode);
    drives_pin = (mode == MODE_TOGGLE) || (mode == MODE_SET_HI) ||
                 (mode == MODE_SET_LO) || (mode[3:2] == 2'b11);
  endfunction : drives_pin

  // Timer B chosen for unit (0 or 1) by the two select bits
  function automatic logic uses_timer_b(input logic hi, input logic lo,
                                        input logic unit2);
    uses_timer_b = hi | (lo & unit2);
  endfunction : uses_timer_b

endpackage : ccu_pkg

// file: ccu_capture.sv
// Capture edge detector and prescaler for one unit.
// Assumes the pin input is already synchronous to pclk.
`timescale 1ns/100ps

module ccu_capture
  import ccu_pkg::*;
(
  input  wire logic       pclk,        // System clock
  input  wire logic       presetn,     // Async reset, active low
  input  wire logic       pin_in,      // Unit pin level
  input  wire logic [3:0] mode,        // Mode select field
  output logic            capture_evt  // One-cycle capture request
);

  logic       pin_q;     // Previous pin level
  logic [3:0] presc_q;   // Rising-edge prescaler
  logic       is_cap;    // Capture mode active
  logic       rise;      // Rising edge seen
  logic       fall;      // Falling edge seen

  assign is_cap = (mode[3:2] == 2'b01);
  assign rise   = pin_in & ~pin_q;
  assign fall   = ~pin_in & pin_q;

  // ==========================================================================
  // Edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 1'b0;
    else
      pin_q <= pin_in;
  end

  // ==========================================================================
  // Prescaler: cleared whenever capture is off. Switching between two
  // capture modes keeps the count, so a first capture may come early.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_q <= 4'h0;
    else if (!is_cap)
      presc_q <= 4'h0;
    else if (rise)
      presc_q <= presc_q + 4'h1;
  end

  // ==========================================================================
  // Event selection by mode
  always_comb
  begin
    case (mode)
      MODE_CAP_FALL: capture_evt = fall;
      MODE_CAP_RISE: capture_evt = rise;
      MODE_CAP_R4:   capture_evt = rise && (presc_q[1:0] == 2'h3);
      MODE_CAP_R16:  capture_evt = rise && (presc_q == 4'hf);
      default:       capture_evt = 1'b0;
    endcase
  end

endmodule : ccu_capture

// file: ccu_top.sv
// Two capture/compare units with an APB register slave.
// Assumes timer counts and pin inputs are synchronous to pclk; the
// timers, port latches and converter live outside and obey the reset
// and start pulses given here.
`timescale 1ns/100ps

module ccu_top
  import ccu_pkg::*;
(
  input  wire logic        pclk,              // System clock
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped
  input  wire logic [15:0] timer_a_count,     // Timer A count
  input  wire logic [15:0] timer_b_count,     // Timer B count
  input  wire logic [9:0]  pwm_count,         // PWM base with fine bits
  input  wire logic        pwm_period,        // PWM period end pulse
  input  wire logic        unit1_pin_in,      // Unit 1 pin level
  input  wire logic        unit2_pin_in,      // Unit 2 pin level
  input  wire logic        unit1_port_latch,  // Unit 1 port data latch
  input  wire logic        unit2_port_latch,  // Unit 2 port data latch
  input  wire logic        adc_enabled,       // Converter enabled
  output logic             unit1_pin,         // Unit 1 pin drive level
  output logic             unit2_pin,         // Unit 2 pin drive level
  output logic             timer_a_reset,     // Timer A reset pulse
  output logic             timer_b_reset,     // Timer B reset pulse
  output logic             adc_start,         // Conversion start pulse
  output logic             unit1_irq,         // Unit 1 interrupt request
  output logic             unit2_irq          // Unit 2 interrupt request
);

  localparam int unsigned NU = 2;  // Number of units

  // ==========================================================================
  // Declarations
  logic [7:0]  tbc_q;            // timebase_b_control
  logic [1:0]  ien_q;            // match_irq_enable per unit
  logic [31:0] prdata_q;         // Read data register
  logic [31:0] rd_mux;           // Read data selection
  logic        mapped;           // Address decodes to a register
  logic        wr_en;            // Write access phase
  logic [7:0]  wbyte;            // Low byte of write data
  logic [7:0]  ctrl_q [NU];      // unit control registers
  logic [15:0] val_q  [NU];      // compare_value_register
  logic [1:0]  dcl_q  [NU];      // PWM duty low-bit latch
  logic [NU-1:0] out_q;          // Compare output latch
  logic [NU-1:0] eq_q;           // Equality seen last cycle
  logic [NU-1:0] flag_q;         // match_flag
  logic [NU-1:0] sev_q;          // Special event pulse
  logic [NU-1:0] ctrl_we;        // Control write strobe
  logic [NU-1:0] lo_we;          // Value low write strobe
  logic [NU-1:0] hi_we;          // Value high write strobe
  logic [NU-1:0] match;          // New compare equality
  logic [NU-1:0] cap_evt;        // Capture request
  logic [NU-1:0] use_b;          // Unit runs from timer B
  logic [NU-1:0] pin_in;         // Pin inputs as a vector
  logic [NU-1:0] port_latch;     // Port latches as a vector
  logic [NU-1:0] pin_out;        // Pin drive as a vector
  logic [NU-1:0] irq;            // Requests as a vector
  logic [3:0]  mode   [NU];      // mode_select_field
  logic [15:0] tcount [NU];      // Selected timer count

  assign pin_in     = {unit2_pin_in, unit1_pin_in};
  assign port_latch = {unit2_port_latch, unit1_port_latch};
  assign unit1_pin  = pin_out[0];
  assign unit2_pin  = pin_out[1];
  assign unit1_irq  = irq[0];
  assign unit2_irq  = irq[1];

  // ==========================================================================
  // APB slave: zero wait states, read data sampled in the setup cycle
  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign wbyte   = pwdata[7:0];
  assign mapped  = (paddr == OFS_TBC) || (paddr == OFS_U1L) ||
                   (paddr == OFS_U1H) || (paddr == OFS_U1C) ||
                   (paddr == OFS_U2L) || (paddr == OFS_U2H) ||
                   (paddr == OFS_U2C) || (paddr == OFS_FLAG) ||
                   (paddr == OFS_IEN);
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // Write strobes per unit; unmapped writes are dropped
  assign ctrl_we = {wr_en && (paddr == OFS_U2C), wr_en && (paddr == OFS_U1C)};
  assign lo_we   = {wr_en && (paddr == OFS_U2L), wr_en && (paddr == OFS_U1L)};
  assign hi_we   = {wr_en && (paddr == OFS_U2H), wr_en && (paddr == OFS_U1H)};

  // Read selection; narrow registers sit in the low bits
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_TBC:  rd_mux[7:0]  = tbc_q;
      OFS_U1L:  rd_mux[7:0]  = val_q[0][7:0];
      OFS_U1H:  rd_mux[7:0]  = val_q[0][15:8];
      OFS_U1C:  rd_mux[7:0]  = ctrl_q[0];
      OFS_U2L:  rd_mux[7:0]  = val_q[1][7:0];
      OFS_U2H:  rd_mux[7:0]  = val_q[1][15:8];
      OFS_U2C:  rd_mux[7:0]  = ctrl_q[1];
      OFS_FLAG: rd_mux[1:0]  = flag_q;
      OFS_IEN:  rd_mux[1:0]  = ien_q;
      default:  rd_mux       = 32'h0000_0000;  // Unmapped reads zero
    endcase
  end

  // Read data captured in setup so it is stable for the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= rd_mux;
  end

  // Shared configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tbc_q <= RST_TBC;
    else if (wr_en && (paddr == OFS_TBC))
      tbc_q <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ien_q <= RST_IEN;
    else if (wr_en && (paddr == OFS_IEN))
      ien_q <= pwdata[1:0];
  end

  // ==========================================================================
  // System outputs: timer resets follow each unit's assigned timer
  assign timer_a_reset = (sev_q[0] & ~use_b[0]) | (sev_q[1] & ~use_b[1]);
  assign timer_b_reset = (sev_q[0] & use_b[0]) | (sev_q[1] & use_b[1]);
  // A start while the converter is off would be lost anyway; gate it here
  assign adc_start = sev_q[1] & adc_enabled;

  // ==========================================================================
  // Per-unit capture/compare/PWM logic
  for (genvar i = 0; i < NU; i++)
  begin : g_unit
    localparam logic [7:0] MASK = (i == 0) ? CTRL1_MASK : CTRL2_MASK;

    assign mode[i]   = ctrl_q[i][3:0];
    assign use_b[i]  = uses_timer_b(tbc_q[TBC_SEL_HI], tbc_q[TBC_SEL_LO],
                                    1'(i));
    assign tcount[i] = use_b[i] ? timer_b_count : timer_a_count;
    // Full-width equality, acted on only at its first cycle
    assign match[i]  = is_compare(mode[i]) && (tcount[i] == val_q[i]) &&
                       !eq_q[i];
    assign irq[i]    = flag_q[i] & ien_q[i];
    assign pin_out[i] = drives_pin(mode[i]) ? out_q[i] : port_latch[i];

    ccu_capture u_cap (
      .pclk        (pclk),
      .presetn     (presetn),
      .pin_in      (pin_in[i]),
      .mode        (mode[i]),
      .capture_evt (cap_evt[i])
    );

    // Control register; absent bits never store
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ctrl_q[i] <= RST_CTRL;
      else if (ctrl_we[i])
        ctrl_q[i] <= wbyte & MASK;
    end

    // Equality history, cleared outside compare so re-entry matches again
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        eq_q[i] <= 1'b0;
      else
        eq_q[i] <= is_compare(mode[i]) && (tcount[i] == val_q[i]);
    end

    // Value register: capture wins over software; high byte is
    // read-only in PWM where it holds the active duty
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        val_q[i] <= RST_VAL;
      else if (cap_evt[i])
        val_q[i] <= tcount[i];
      else if (mode[i][3:2] == 2'b11 && pwm_period)
        val_q[i][15:8] <= val_q[i][7:0];
      else if (lo_we[i])
        val_q[i][7:0] <= wbyte;
      else if (hi_we[i] && mode[i][3:2] != 2'b11)
        val_q[i][15:8] <= wbyte;
    end

    // Duty low-bit latch, double-buffered with the high byte
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        dcl_q[i] <= 2'h0;
      else if (mode[i][3:2] == 2'b11 && pwm_period)
        dcl_q[i] <= ctrl_q[i][CTRL_DC_LSB +: 2];
    end

    // Compare/PWM output latch
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        out_q[i] <= 1'b0;
      else if (ctrl_we[i])
      begin
        // Writes of mode 1000 or 1001 initialise the latch; a zero write forces it low
        if (wbyte == 8'h00)
          out_q[i] <= 1'b0;
        else if (wbyte[3:0] == MODE_SET_HI)
          out_q[i] <= 1'b0;
        else if (wbyte[3:0] == MODE_SET_LO)
          out_q[i] <= 1'b1;
      end
      else if (mode[i][3:2] == 2'b11)
      begin
        // PWM: set at period end unless duty is zero, clear on duty match
        if (pwm_period)
          out_q[i] <= ({val_q[i][7:0], ctrl_q[i][CTRL_DC_LSB +: 2]} != 10'h000);
        else if ({val_q[i][15:8], dcl_q[i]} == pwm_count)
          out_q[i] <= 1'b0;
      end
      else if (match[i])
      begin
        case (mode[i])
          MODE_SET_HI: out_q[i] <= 1'b1;
          MODE_SET_LO: out_q[i] <= 1'b0;
          MODE_TOGGLE: out_q[i] <= ~out_q[i];
          default:     out_q[i] <= out_q[i];
        endcase
      end
    end

    // Match flag: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        flag_q[i] <= 1'b0;
      else if (match[i] || cap_evt[i])
        flag_q[i] <= 1'b1;
      else if (wr_en && (paddr == OFS_FLAG) && pwdata[i])
        flag_q[i] <= 1'b0;
    end

    // Special event, registered so it is exactly one cycle wide
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        sev_q[i] <= 1'b0;
      else
        sev_q[i] <= match[i] && (mode[i] == MODE_SEV);
    end

    // ========================================================================
    // Assertions
    a_flag_on_match: assert property (
      @(posedge pclk) disable iff (!presetn) match[i] |=> flag_q[i])
      else $error("match flag not set after compare match");

    a_pin_set_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      match[i] && mode[i] == MODE_SET_HI && !ctrl_we[i] |=> out_q[i] && pin_out[i])
      else $error("pin not driven high on match");

    a_swint_pin_kept: assert property (
      @(posedge pclk) disable iff (!presetn)
      match[i] && mode[i] == MODE_SWINT && !ctrl_we[i] |=>
      $stable(out_q[i]) && pin_out[i] == port_latch[i])
      else $error("software interrupt mode changed the pin");

    a_irq_gated: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq[i] |-> flag_q[i] && ien_q[i])
      else $error("interrupt without flag and enable");

    a_sev_single: assert property (
      @(posedge pclk) disable iff (!presetn) sev_q[i] |=> !sev_q[i])
      else $error("special event longer than one cycle");

    a_sev_cause: assert property (
      @(posedge pclk) disable iff (!presetn)
      sev_q[i] |-> $past(match[i]) && $past(mode[i]) == MODE_SEV)
      else $error("special event without a mode 1011 match");

    a_timer_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      sev_q[i] |-> (use_b[i] ? timer_b_reset : timer_a_reset))
      else $error("special event did not reset its timer");

    a_zero_clears: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl_we[i] && wbyte == 8'h00 |=> !out_q[i] && mode[i] == MODE_OFF)
      else $error("zero control write left latch high");

    a_match_once: assert property (
      @(posedge pclk) disable iff (!presetn) match[i] |=> !match[i])
      else $error("one equality acted on twice");

    a_capture_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      cap_evt[i] |=> val_q[i] == $past(tcount[i]))
      else $error("capture did not load the timer count");
  end

  a_rsvd_zero: assert property (
    @(posedge pclk) disable iff (!presetn) (ctrl_q[1] & ~CTRL2_MASK) == 8'h00)
    else $error("unit 2 unimplemented control bits not zero");

  a_adc_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    adc_start |-> adc_enabled && $past(match[1]) && $past(mode[1]) == MODE_SEV)
    else $error("conversion start without unit 2 event");

endmodule : ccu_top

// file: ccu_timer_model.sv
// Model of the two time-base timers and the converter start logic.
// Assumes reset and start pulses from the unit are synchronous to pclk.
`timescale 1ns/100ps

module ccu_timer_model
(
  input  wire logic        pclk,           // System clock
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        timer_a_reset,  // Timer A reset pulse
  input  wire logic        timer_b_reset,  // Timer B reset pulse
  input  wire logic        adc_start,      // Conversion start pulse
  input  wire logic        adc_enabled,    // Converter enabled
  output logic      [15:0] timer_a_count,  // Timer A count
  output logic      [15:0] timer_b_count,  // Timer B count
  output int               conversions     // Conversions started
);
  // ==========================================================
  // Timers
  // Both run in timer mode, one step per clock, never asynchronous
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_a_count <= 16'h0000;
      timer_b_count <= 16'h0000;
    end
    else
    begin
      // A special event clears the count instead of stepping it
      timer_a_count <= timer_a_reset ? 16'h0000 : timer_a_count + 16'h0001;
      timer_b_count <= timer_b_reset ? 16'h0000 : timer_b_count + 16'h0001;
    end
  end

  // ==========================================================
  // Converter
  // A start only counts while the converter is enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conversions <= 0;
    else if (adc_start && adc_enabled)
      conversions <= conversions + 1;
  end
endmodule : ccu_timer_model

// file: tb.sv
// Self-checking bench for the capture/compare block over APB.
// Assumes the timer model drives the counts; scenarios drive capture and PWM inputs.
`timescale 1ns/100ps

module tb;
  import ccu_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;  // Clock, reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0]  paddr = 8'h00;                // APB address
  logic [31:0] pwdata = 32'h0, prdata, rd;   // APB data, last read
  logic        pready, pslverr, err;         // APB answer
  logic [15:0] ta, tb_c, v;                  // Timer counts, compare value
  logic        p1l = 1'b1, p2l = 1'b1, adc_en = 1'b1; // Port latches, converter
  logic        pper = 1'b0, cp1 = 1'b0;               // PWM period end, unit 1 pin in
  logic [9:0]  pcnt = 10'h000;                        // PWM base count
  logic        pin1, pin2, ra, rb, adc, irq1, irq2;   // Design outputs
  int          fail_count = 0, n_compared = 0, cyc = 0, conv, na, nb, nc, c0;

  ccu_top i_ccu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_a_count(ta), .timer_b_count(tb_c), .pwm_count(pcnt),
    .pwm_period(pper), .unit1_pin_in(cp1), .unit2_pin_in(1'b0), .unit1_port_latch(p1l),
    .unit2_port_latch(p2l), .adc_enabled(adc_en), .unit1_pin(pin1), .unit2_pin(pin2),
    .timer_a_reset(ra), .timer_b_reset(rb), .adc_start(adc), .unit1_irq(irq1),
    .unit2_irq(irq2));
  ccu_timer_model i_ccu_timer_model (.pclk(pclk), .presetn(presetn), .timer_a_reset(ra),
    .timer_b_reset(rb), .adc_start(adc), .adc_enabled(adc_en), .timer_a_count(ta),
    .timer_b_count(tb_c), .conversions(conv));

  // ==========================================================
  // Clock and hang guard
  always #2.5 pclk = ~pclk;
  // A hang in any wait ends here with a mismatch counted
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Load a 16-bit compare value into the unit whose low-byte offset is given
  task automatic load(input logic [7:0] lo, input logic [15:0] val);
    apb(1'b1, lo, val[7:0]);
    apb(1'b1, lo + 8'h04, val[15:8]);
  endtask : load

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, OFS_TBC, 8'h00);  chk(rd, 32'h0);
    apb(1'b1, OFS_U1C, 8'h3f);  apb(1'b0, OFS_U1C, 8'h00); chk(rd, 32'h3f);
    apb(1'b1, OFS_U2C, 8'hff);  apb(1'b0, OFS_U2C, 8'h00); chk(rd, 32'h3f);
    apb(1'b0, 8'h24, 8'h00);    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, OFS_U1C, 8'h00);  apb(1'b1, OFS_U2C, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // Drive-high match on timer A, then flag and interrupt handling
  task automatic t_set_hi();
    v = ta + 16'h0040;
    load(OFS_U1L, v);
    apb(1'b1, OFS_U1C, MODE_SET_HI);
    @(negedge pclk);  chk(pin1, 1'b0);
    while (pin1 !== 1'b1) @(negedge pclk);
    chk(ta, v + 16'h0001);
    apb(1'b0, OFS_FLAG, 8'h00); chk(rd, 32'h1);
    chk(irq1, 1'b0);
    apb(1'b1, OFS_IEN, 8'h01);  @(negedge pclk); chk(irq1, 1'b1);
    apb(1'b1, OFS_FLAG, 8'h01); @(negedge pclk); chk(irq1, 1'b0);
    chk(pin1, 1'b1);
    apb(1'b1, OFS_U1C, 8'h00);
    $display("test set_hi done");
  endtask : t_set_hi

  // Flag-only mode leaves the pin on the port latch
  task automatic t_swint();
    p1l <= 1'b0;
    v = ta + 16'h0030;
    load(OFS_U1L, v);
    apb(1'b1, OFS_U1C, MODE_SWINT);
    while (irq1 !== 1'b1) @(negedge pclk);
    chk(pin1, 1'b0);
    @(posedge pclk);  p1l <= 1'b1;
    @(negedge pclk);  chk(pin1, 1'b1);
    apb(1'b1, OFS_IEN, 8'h00);  apb(1'b1, OFS_FLAG, 8'h01);
    apb(1'b1, OFS_U1C, 8'h00);
    $display("test swint done");
  endtask : t_swint

  // Rising-edge capture loads the timer A count seen at that edge
  task automatic t_cap();
    apb(1'b1, OFS_U1C, 8'h00);  apb(1'b1, OFS_U1C, MODE_CAP_RISE);
    @(posedge pclk);  cp1 <= 1'b1;
    @(negedge pclk);  v = ta;
    apb(1'b0, OFS_U1L, 8'h00);  chk(rd, {24'h0, v[7:0]});
    apb(1'b0, OFS_U1H, 8'h00);  chk(rd, {24'h0, v[15:8]});
    apb(1'b0, OFS_FLAG, 8'h00); chk(rd[0], 1'b1);
    apb(1'b1, OFS_U1C, 8'h00);  apb(1'b1, OFS_FLAG, 8'h01);
    @(posedge pclk);  cp1 <= 1'b0;
    $display("test cap done");
  endtask : t_cap

  // PWM: period end sets the pin and loads the duty, duty match clears it
  task automatic t_pwm();
    apb(1'b1, OFS_U1L, 8'h02);  apb(1'b1, OFS_U1C, 8'h1c);
    @(posedge pclk);  pper <= 1'b1;  pcnt <= 10'h3ff;
    @(posedge pclk);  pper <= 1'b0;
    @(negedge pclk);  chk(pin1, 1'b1);
    apb(1'b0, OFS_U1H, 8'h00);  chk(rd, 32'h2);
    @(posedge pclk);  pcnt <= 10'h009;
    repeat (2) @(negedge pclk);
    chk(pin1, 1'b0);
    apb(1'b1, OFS_U1C, 8'h00);
    $display("test pwm done");
  endtask : t_pwm

  // Unit 2 special event on timer B: one reset pulse and one start
  task automatic t_sev();
    apb(1'b1, OFS_TBC, 8'h08);
    v = tb_c + 16'h0040;
    load(OFS_U2L, v);
    c0 = conv; na = 0; nb = 0; nc = 0;
    apb(1'b1, OFS_U2C, MODE_SEV);
    repeat (120)
    begin
      @(negedge pclk);
      na += ra; nb += rb; nc += adc;
    end
    chk(nb, 1); chk(nc, 1); chk(na, 0);
    chk(conv - c0, 1);
    chk(tb_c < 16'h0080, 1'b1);
    apb(1'b0, OFS_FLAG, 8'h00); chk(rd, 32'h2);
    apb(1'b1, OFS_U2C, 8'h00);  apb(1'b1, OFS_FLAG, 8'h02);
    $display("test sev done");
  endtask : t_sev

  // A zero control write clears the compare latch, not the port latch
  task automatic t_zero();
    p2l <= 1'b0;
    apb(1'b1, OFS_U2H, 8'hff);
    apb(1'b1, OFS_U2C, MODE_SET_LO); @(negedge pclk); chk(pin2, 1'b1);
    apb(1'b1, OFS_U2C, 8'h00);       @(negedge pclk); chk(pin2, 1'b0);
    @(posedge pclk);  p2l <= 1'b1;
    v = tb_c + 16'h0020;
    load(OFS_U2L, v);
    apb(1'b1, OFS_U2C, MODE_TOGGLE); @(negedge pclk); chk(pin2, 1'b0);
    while (pin2 !== 1'b1) @(negedge pclk);
    chk(tb_c, v + 16'h0001);
    apb(1'b1, OFS_U2C, 8'h00);       @(negedge pclk); chk(pin2, 1'b1);
    apb(1'b1, OFS_U2C, MODE_TOGGLE); @(negedge pclk); chk(pin2, 1'b0);
    apb(1'b1, OFS_U2C, 8'h00);       apb(1'b1, OFS_FLAG, 8'h02);
    $display("test zero done");
  endtask : t_zero

  // ==========================================================
  // Verdict
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_set_hi();
    t_swint();
    t_cap();
    t_pwm();
    t_sev();
    t_zero();
    complete_run();
  end
endmodule : tb
